// file: shared/psv_map.vh
// constants for the program sequencer: widths, phases, vectors, start-up count
// assumes inclusion by bare name from every sequencer design file
`ifndef PSV_MAP_VH
`define PSV_MAP_VH
// ==========================================================
// widths and sizes
`define PSV_PC_W 12
`define PSV_INSTR_W 15
`define PSV_PROM_WORDS 4096
`define PSV_STACK_LEVELS 16
`define PSV_SP_W 4
`define PSV_DEPTH_W 5
`define PSV_DEPTH_FULL 5'h10
`define PSV_PAGE_HI 11
`define PSV_PAGE_LO 8
`define PSV_IRQ_N 6
`define PSV_IRQ_IDX_W 3
// ==========================================================
// one-hot phases of an instruction cycle
`define PSV_PH_W 4
`define PSV_PH_T1 4'h1
`define PSV_PH_T2 4'h2
`define PSV_PH_T3 4'h4
`define PSV_PH_T4 4'h8
// ==========================================================
// fixed entry addresses
`define PSV_VEC_RESET 12'h000
`define PSV_VEC_USB 12'h004
`define PSV_VEC_TMR0 12'h008
`define PSV_VEC_TMR1 12'h00C
`define PSV_VEC_PLAY 12'h010
`define PSV_VEC_SPI 12'h014
`define PSV_VEC_REC 12'h018
// interrupt source index, lower index wins
`define PSV_IRQ_USB 3'h0
`define PSV_IRQ_TMR0 3'h1
`define PSV_IRQ_TMR1 3'h2
`define PSV_IRQ_PLAY 3'h3
`define PSV_IRQ_SPI 3'h4
`define PSV_IRQ_REC 3'h5
// ==========================================================
// start-up wait, in system clock periods, and the cycle count from it
`define PSV_SST_TSYS 1024
`define PSV_CLK_PER_TSYS 1
`define PSV_SST_CYCLES (`PSV_SST_TSYS * `PSV_CLK_PER_TSYS)
`define PSV_SST_W 11
`endif

// file: logic/psv_prom.v
// program memory: 4096 words of 15 bits, one fetch port and one table port
// assumes a loader on the same clock fills it before the sequencer runs
`timescale 1ns/100ps
`include "psv_map.vh"
module psv_prom (
  input wire clk_sys,
  input wire load_we,
  input wire [`PSV_PC_W-1:0] load_addr,
  input wire [`PSV_INSTR_W-1:0] load_data,
  input wire [`PSV_PC_W-1:0] fetch_addr,
  output reg [`PSV_INSTR_W-1:0] fetch_data,
  input wire [`PSV_PC_W-1:0] table_addr,
  output reg [`PSV_INSTR_W-1:0] table_data
);
  // ==========================================================
  // storage
  reg [`PSV_INSTR_W-1:0] mem [0:`PSV_PROM_WORDS-1];

  // reads are registered; the sequencer holds the fetch address steady for a whole cycle
  always @(posedge clk_sys) begin
    if (load_we) begin
      mem[load_addr] <= load_data;
    end
    fetch_data <= mem[fetch_addr];
    table_data <= mem[table_addr];
  end
endmodule

// file: logic/psv_seq.v
// program sequencer: phase generator, fetch/execute pipeline, program counter,
// return stack and interrupt vectoring.
// assumes the decoder, interrupt flags and enables run on clk_sys and that
// decoder requests are held valid through phase four of each cycle.
`timescale 1ns/100ps
`include "psv_map.vh"
module psv_seq (
  input wire clk_sys,
  input wire reset_n,
  input wire load_we,
  input wire [`PSV_PC_W-1:0] load_addr,
  input wire [`PSV_INSTR_W-1:0] load_data,
  output reg [`PSV_PH_W-1:0] phase,
  output reg running,
  output wire cycle_end,
  output reg [`PSV_INSTR_W-1:0] exec_instr,
  output reg exec_valid,
  output reg [`PSV_PC_W-1:0] pc,
  output wire [7:0] pc_low_byte,
  input wire op_jump,
  input wire op_call,
  input wire op_ret,
  input wire op_skip,
  input wire pcl_write,
  input wire [7:0] pcl_wdata,
  input wire [`PSV_PC_W-1:0] table_ptr,
  output wire [`PSV_INSTR_W-1:0] table_data,
  input wire [`PSV_IRQ_N-1:0] irq_flag,
  input wire [`PSV_IRQ_N-1:0] irq_enable,
  input wire irq_global_enable,
  output reg irq_ack,
  output reg [`PSV_IRQ_IDX_W-1:0] irq_ack_src,
  output wire stack_full
);
  // ==========================================================
  // start-up timer
  reg [`PSV_SST_W-1:0] sst_count;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sst_count <= {`PSV_SST_W{1'b0}};
      running <= 1'b0;
    end else if (!running) begin
      if (sst_count == `PSV_SST_CYCLES - 1) begin
        running <= 1'b1;
      end else begin
        sst_count <= sst_count + 1'b1;
      end
    end
  end

  // ==========================================================
  // phase generator; phases stay parked at T1 until start-up ends
  reg [`PSV_PH_W-1:0] next_phase;

  always @* begin
    case (phase)
      `PSV_PH_T1: next_phase = `PSV_PH_T2;
      `PSV_PH_T2: next_phase = `PSV_PH_T3;
      `PSV_PH_T3: next_phase = `PSV_PH_T4;
      `PSV_PH_T4: next_phase = `PSV_PH_T1;
      default: next_phase = `PSV_PH_T1;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase <= `PSV_PH_T1;
    end else if (running) begin
      phase <= next_phase;
    end
  end

  // every register update of the pipeline happens on this edge
  assign cycle_end = running && (phase == `PSV_PH_T4);

  // ==========================================================
  // program memory
  wire [`PSV_INSTR_W-1:0] fetch_data;

  psv_prom i_psv_prom (
    .clk_sys(clk_sys),
    .load_we(load_we),
    .load_addr(load_addr),
    .load_data(load_data),
    .fetch_addr(pc),
    .fetch_data(fetch_data),
    .table_addr(table_ptr),
    .table_data(table_data)
  );

  // ==========================================================
  // return stack; a call into a full stack overwrites the oldest entry
  reg [`PSV_PC_W-1:0] stack_mem [0:`PSV_STACK_LEVELS-1];
  reg [`PSV_SP_W-1:0] sp;
  reg [`PSV_DEPTH_W-1:0] depth;
  wire [`PSV_SP_W-1:0] sp_top;

  assign sp_top = sp - 1'b1;
  assign stack_full = (depth == `PSV_DEPTH_FULL);

  // ==========================================================
  // execute-slot decisions, only honoured for a real instruction
  wire do_jump;
  wire do_call;
  wire do_ret;
  wire do_skip;
  wire do_pcl;
  wire flow_change;

  assign do_jump = exec_valid && op_jump;
  assign do_call = exec_valid && op_call;
  assign do_ret = exec_valid && op_ret;
  assign do_skip = exec_valid && op_skip;
  assign do_pcl = exec_valid && pcl_write;
  assign flow_change = do_jump || do_call || do_ret || do_skip || do_pcl;

  // ==========================================================
  // interrupt arbitration; lowest vector wins
  wire [`PSV_IRQ_N-1:0] irq_live;
  reg irq_any;
  reg [`PSV_IRQ_IDX_W-1:0] irq_sel;
  reg [`PSV_PC_W-1:0] irq_vector;
  wire irq_take;
  integer i;

  assign irq_live = irq_flag & irq_enable & {`PSV_IRQ_N{irq_global_enable}};

  always @* begin
    irq_any = 1'b0;
    irq_sel = `PSV_IRQ_USB;
    for (i = `PSV_IRQ_N - 1; i >= 0; i = i - 1) begin
      if (irq_live[i]) begin
        irq_any = 1'b1;
        irq_sel = i[`PSV_IRQ_IDX_W-1:0];
      end
    end
  end

  always @* begin
    case (irq_sel)
      `PSV_IRQ_USB: irq_vector = `PSV_VEC_USB;
      `PSV_IRQ_TMR0: irq_vector = `PSV_VEC_TMR0;
      `PSV_IRQ_TMR1: irq_vector = `PSV_VEC_TMR1;
      `PSV_IRQ_PLAY: irq_vector = `PSV_VEC_PLAY;
      `PSV_IRQ_SPI: irq_vector = `PSV_VEC_SPI;
      `PSV_IRQ_REC: irq_vector = `PSV_VEC_REC;
      default: irq_vector = `PSV_VEC_RESET;
    endcase
  end

  // taken only between flow changes so the pushed address is always the
  // discarded fetch; a full stack leaves the flag pending at its source
  assign irq_take = cycle_end && irq_any && !flow_change && !stack_full;

  // ==========================================================
  // program counter and pipeline
  reg [`PSV_PC_W-1:0] next_pc;

  assign pc_low_byte = pc[`PSV_PAGE_LO-1:0];

  always @* begin
    next_pc = pc + 1'b1;
    if (irq_take) begin
      next_pc = irq_vector;
    end else if (do_jump || do_call) begin
      next_pc = exec_instr[`PSV_PC_W-1:0];
    end else if (do_ret) begin
      next_pc = stack_mem[sp_top];
    end else if (do_pcl) begin
      // page bits come from the counter itself
      next_pc = {pc[`PSV_PAGE_HI:`PSV_PAGE_LO], pcl_wdata};
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc <= `PSV_VEC_RESET;
      exec_instr <= {`PSV_INSTR_W{1'b0}};
      exec_valid <= 1'b0;
    end else if (cycle_end) begin
      pc <= next_pc;
      exec_instr <= fetch_data;
      // the word fetched alongside a flow change is dropped as a dummy cycle
      exec_valid <= !(flow_change || irq_take);
    end
  end

  // ==========================================================
  // stack pointer and acknowledge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sp <= {`PSV_SP_W{1'b0}};
      depth <= {`PSV_DEPTH_W{1'b0}};
      irq_ack <= 1'b0;
      irq_ack_src <= `PSV_IRQ_USB;
    end else begin
      irq_ack <= irq_take;
      if (irq_take) begin
        irq_ack_src <= irq_sel;
      end
      if (irq_take || (cycle_end && do_call)) begin
        sp <= sp + 1'b1;
        if (!stack_full) begin
          depth <= depth + 1'b1;
        end
      end else if (cycle_end && do_ret) begin
        sp <= sp_top;
        if (depth != {`PSV_DEPTH_W{1'b0}}) begin
          depth <= depth - 1'b1;
        end
      end
    end
  end

  // pushed value is the fetch address, i.e. the next word to execute on return
  always @(posedge clk_sys) begin
    if (irq_take || (cycle_end && do_call)) begin
      stack_mem[sp] <= pc;
    end
  end
endmodule

// file: sim/psv_seq_chk.sv
// checker for the program sequencer: phases, counter, dummy cycles, vectors
// assumes it is bound into psv_seq and sees only its ports
`timescale 1ns/100ps
module psv_seq_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire [3:0] phase,
  input wire running,
  input wire cycle_end,
  input wire [14:0] exec_instr,
  input wire exec_valid,
  input wire [11:0] pc,
  input wire [7:0] pc_low_byte,
  input wire op_jump,
  input wire op_call,
  input wire op_ret,
  input wire op_skip,
  input wire pcl_write,
  input wire [7:0] pcl_wdata,
  input wire [5:0] irq_flag,
  input wire [5:0] irq_enable,
  input wire irq_global_enable,
  input wire irq_ack,
  input wire [2:0] irq_ack_src,
  input wire stack_full
);
  // ==========================================
  // helpers
  wire flow = exec_valid & (op_jump | op_call | op_ret | op_skip | pcl_write);
  wire [5:0] req = irq_flag & irq_enable;
  // skip is treated as a flow change, so a skipping slot is never judged for irq
  wire go = (|req) & irq_global_enable & ~stack_full & ~flow;
  wire [11:0] target = exec_instr[11:0];
  wire [3:0] page = pc[11:8];
  reg [2:0] win;
  reg [10:0] wait_cnt;
  integer i;
  always @* begin
    win = 3'h0;
    for (i = 5; i >= 0; i = i - 1)
      if (req[i])
        win = i[2:0];
  end
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      wait_cnt <= 11'h000;
    else if (!running)
      wait_cnt <= wait_cnt + 11'h001;
  // ==========================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_phase_walk: assert property (running && !cycle_end |=> phase == $past(phase) << 1)
    else $error("phase did not step");
  a_phase_wrap: assert property (cycle_end |=> phase == 4'h1)
    else $error("phase did not wrap");
  a_start_wait: assert property ($rose(running) |-> wait_cnt == 11'h400 && pc == 12'h000)
    else $error("start-up wait or start address wrong");
  a_pc_step: assert property (cycle_end && !flow && !go |=> pc == $past(pc) + 12'h001)
    else $error("counter did not step by one");
  a_branch_load: assert property (cycle_end && exec_valid && (op_jump || op_call) |=> pc == $past(target))
    else $error("branch target not loaded");
  a_low_jump: assert property (cycle_end && exec_valid && pcl_write && !(op_jump || op_call || op_ret)
    |=> pc == {$past(page), $past(pcl_wdata)})
    else $error("low byte jump wrong");
  a_low_read: assert property (pc_low_byte == pc[7:0])
    else $error("low byte readback wrong");
  a_skip_drop: assert property (cycle_end && exec_valid && op_skip |=> !exec_valid)
    else $error("skipped word not dropped");
  a_dummy_one: assert property (cycle_end && (flow || go) |=> !exec_valid)
    else $error("no dummy cycle");
  a_refill_next: assert property (cycle_end && !exec_valid && !go |=> exec_valid)
    else $error("pipeline not refilled");
  // acknowledge is registered on the taking edge, so it stands beside the new counter
  a_vector_take: assert property (cycle_end && go |=> pc == {7'h00, $past(win) + 3'h1, 2'h0}
    && irq_ack && irq_ack_src == $past(win))
    else $error("vector or acknowledge wrong");
  a_full_refuse: assert property (cycle_end && stack_full |=> !irq_ack)
    else $error("acknowledge with full stack");
endmodule
bind psv_seq psv_seq_chk i_psv_seq_chk (.clk_sys, .reset_n, .phase, .running, .cycle_end,
  .exec_instr, .exec_valid, .pc, .pc_low_byte, .op_jump, .op_call, .op_ret, .op_skip,
  .pcl_write, .pcl_wdata, .irq_flag, .irq_enable, .irq_global_enable, .irq_ack,
  .irq_ack_src, .stack_full);

// file: sim/psv_seq_tb.sv
// bench for the program sequencer: loads memory, plays decoder and irq sources
// assumes a 10 MHz clock; all inputs change on the falling edge
`timescale 1ns/100ps
module psv_seq_tb;
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg load_we = 1'b0;
  reg [11:0] load_addr = 12'h000;
  reg [14:0] load_data = 15'h0000;
  reg [4:0] ops = 5'h00;
  reg [7:0] wd = 8'h00;
  reg [11:0] table_ptr = 12'h000;
  reg [5:0] irq_flag = 6'h00;
  reg [5:0] irq_en = 6'h3F;
  reg gen = 1'b1;
  wire [3:0] phase;
  wire running, cycle_end, exec_valid, stack_full, irq_ack;
  wire [14:0] exec_instr, table_data;
  wire [11:0] pc;
  wire [7:0] pc_low_byte;
  wire [2:0] irq_ack_src;
  reg [11:0] fa;
  reg [11:0] t;
  reg [14:0] se;
  integer fail_count = 0;
  integer n_tests = 0;
  integer i;
  always #50 clk_sys = ~clk_sys;
  // enables are driven so that masking can be exercised, not only assumed
  psv_seq i_psv_seq (.clk_sys, .reset_n, .load_we, .load_addr, .load_data, .phase,
    .running, .cycle_end, .exec_instr, .exec_valid, .pc, .pc_low_byte,
    .op_jump(ops[0]), .op_call(ops[1]), .op_ret(ops[2]), .op_skip(ops[3]),
    .pcl_write(ops[4]), .pcl_wdata(wd), .table_ptr, .table_data, .irq_flag,
    .irq_enable(irq_en), .irq_global_enable(gen), .irq_ack, .irq_ack_src, .stack_full);
  // ==========================================
  // shared tasks
  function [14:0] wv(input [11:0] a);
    wv = {3'h3, a + 12'h100};
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task bound(input integer k, input integer lim);
    if (k >= lim) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  endtask
  // one decoder request in the next valid execute slot
  task slot(input [4:0] op, input [7:0] d, input [5:0] q);
    integer k;
    k = 0;
    @(negedge clk_sys);
    while (!(cycle_end === 1'b1 && exec_valid === 1'b1) && k < 40) begin
      @(negedge clk_sys);
      k = k + 1;
    end
    bound(k, 40);
    fa = pc;
    se = exec_instr;
    ops = op;
    wd = d;
    irq_flag = q;
    @(negedge clk_sys);
    ops = 5'h00;
  endtask
  // ==========================================
  // scenarios
  task t_start;
    integer k;
    k = 0;
    while (running !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k = k + 1;
    end
    chk(k, 1024);
    bound(k, 2000);
    chk(pc, 12'h000);
    for (k = 0; k < 4; k = k + 1) begin
      chk(phase, 16'h1 << k);
      chk(cycle_end, k == 3);
      @(negedge clk_sys);
    end
  endtask
  task t_flow;
    slot(5'h00, 8'h00, 6'h00);
    chk(exec_instr, wv(fa));
    chk(pc, fa + 12'h001);
    slot(5'h01, 8'h00, 6'h00);
    t = se[11:0];
    chk(pc, t);
    chk(exec_valid, 1'b0);
    slot(5'h00, 8'h00, 6'h00);
    chk(se, wv(t));
    slot(5'h08, 8'h00, 6'h00);
    t = fa;
    chk(exec_valid, 1'b0);
    slot(5'h00, 8'h00, 6'h00);
    chk(se, wv(t + 12'h001));
    // 8'hFF would carry into the page if the write were an add
    slot(5'h10, 8'hFF, 6'h00);
    chk(pc, {fa[11:8], 8'hFF});
    chk(pc_low_byte, 8'hFF);
    slot(5'h02, 8'h00, 6'h00);
    chk(pc, se[11:0]);
    t = fa;
    slot(5'h04, 8'h00, 6'h00);
    chk(pc, t);
  endtask
  task t_irq;
    for (i = 0; i < 6; i = i + 1) begin
      slot(5'h00, 8'h00, 6'h3F << i);
      chk(pc, 12'h004 * (i + 1));
      // the acknowledge stands for one clock only, right after the taking edge
      chk(irq_ack, 1'b1);
      chk(irq_ack_src, i);
      irq_flag = 6'h00;
      t = fa;
      slot(5'h04, 8'h00, 6'h00);
      chk(pc, t);
    end
  endtask
  task t_mask;
    irq_en = 6'h3E;
    slot(5'h00, 8'h00, 6'h01);
    chk(pc, fa + 12'h001);
    chk(irq_ack, 1'b0);
    // the usb flag still stands, so the master enable must be off first
    irq_en = 6'h3F;
    gen = 1'b0;
    slot(5'h00, 8'h00, 6'h3F);
    chk(pc, fa + 12'h001);
    chk(irq_ack, 1'b0);
    irq_flag = 6'h00;
    gen = 1'b1;
  endtask
  task t_full;
    chk(stack_full, 1'b0);
    for (i = 0; i < 16; i = i + 1)
      slot(5'h02, 8'h00, 6'h00);
    chk(stack_full, 1'b1);
    slot(5'h00, 8'h00, 6'h01);
    repeat (8) begin
      chk(irq_ack, 1'b0);
      @(negedge clk_sys);
    end
    slot(5'h04, 8'h00, 6'h01);
    i = 0;
    while (irq_ack !== 1'b1 && i < 12) begin
      @(negedge clk_sys);
      i = i + 1;
    end
    bound(i, 12);
    irq_flag = 6'h00;
    chk(irq_ack_src, 3'h0);
  endtask
  task t_table;
    @(negedge clk_sys);
    table_ptr = 12'hFFF;
    @(negedge clk_sys);
    chk(table_data, wv(12'hFFF));
  endtask
  // ==========================================
  // main sequence
  initial begin
    for (i = 0; i < 4096; i = i + 1) begin
      @(negedge clk_sys);
      load_we = 1'b1;
      load_addr = i[11:0];
      load_data = wv(i[11:0]);
    end
    @(negedge clk_sys);
    load_we = 1'b0;
    repeat (10) @(negedge clk_sys);
    reset_n = 1'b1;
    t_start;
    t_flow;
    t_irq;
    t_mask;
    t_full;
    t_table;
    stop_test;
  end
endmodule
